// file: src/cfl_flags.v
// Condition flags, interrupt priority level, vectors and halt wake
`timescale 1ns/1ps
`default_nettype none
`include "cfl_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Add and add-with-carry set half carry on a carry out of bit 3 and clear it otherwise.
// - The negative flag at bit 2 copies bit 7 of the last arithmetic, logic or data result.
// - The zero flag at bit 1 is set when that result is zero and cleared when it is not.
// - Carry at bit 0 records arithmetic overflow or borrow, follows bit test, shift and rotate, and set/reset carry.
// - Priority bits 5 and 3 code level 0 as 10, level 1 as 01, level 2 as 00 and level 3 (disabled) as 11.
// - Entering an interrupt loads both priority bits from that source's software priority setting.
// - Enable, disable, return, halt, wait and pop instructions also write the priority bits.
// - The whole register can be pushed and popped, and bits 0 to 5 tested and controlled alone; bits 6 and 7 always read 1.
// - The flash programming interrupt, source 0, vectors to FFFA-FFFB and wakes from halt.
// - The USB end-of-suspend interrupt, source 1, vectors to FFF8-FFF9 and wakes from halt.
// - Port A lines vector to FFF6-FFF7 and port B lines to FFF4-FFF5, both waking from halt.
// - Port C lines vector to FFF2-FFF3 and wake from halt.
module cfl_flags (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        ex_valid,
  input  wire [3:0]  ex_op,
  input  wire [7:0]  ex_a,
  input  wire [7:0]  ex_b,
  input  wire        ex_cbit,
  input  wire [2:0]  ex_bit_sel,
  input  wire        ex_bit_val,
  input  wire        irq_enter,
  input  wire [2:0]  irq_src,
  input  wire [1:0]  irq_level,
  input  wire [4:0]  irq_pend,
  input  wire [2:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [7:0]  reg_rdata,
  output wire [7:0]  state_out,
  output wire [1:0]  cur_level,
  output wire        irq_disabled,
  output reg  [7:0]  alu_result,
  output reg  [15:0] vec_addr,
  output reg         vec_wake,
  output wire        halted,
  output wire        irq_out
);

  localparam ST_RUN  = 2'b01;
  localparam ST_HALT = 2'b10;

  reg  [7:0]           cc_q;
  reg  [7:0]           cc_d;
  reg  [7:0]           flash_program_control_status_q;
  reg  [`CFL_NEV-1:0]  stat_q;
  reg  [`CFL_NEV-1:0]  mask_q;
  reg  [1:0]           st_q;
  reg  [1:0]           st_d;
  reg  [7:0]           res;
  reg  [8:0]           sum9;
  reg  [4:0]           sum5;
  reg  [8:0]           dif9;
  reg                  cin;
  reg                  carry_ev;
  wire [15:0]          rom_vec;
  wire                 rom_wake;
  wire [`CFL_NSRC-1:0] wake_hit;
  wire [`CFL_NSRC-1:0] wake_mask;
  wire                 wake_any;
  wire [`CFL_NEV-1:0]  ev;

  assign state_out    = cc_q;
  assign cur_level    = {cc_q[`CFL_BIT_PHI], cc_q[`CFL_BIT_PLO]};
  assign irq_disabled = (cur_level == `CFL_LVL_OFF);
  assign halted       = (st_q == ST_HALT);

  ////////////////////////////////////////////////////////////////////////////////
  // Vector lookup for the source being entered

  cfl_vector_rom u_rom (
    .src      (irq_src),
    .vec_addr (rom_vec),
    .can_wake (rom_wake)
  );

  always @(posedge clk) begin
    if (!rst_b) begin
      vec_addr <= `CFL_VEC_NONE;
      vec_wake <= 1'b0;
    end else if (irq_enter) begin
      vec_addr <= rom_vec;
      vec_wake <= rom_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Halt wake per source

  // One mask bit per source, so each pending line is gated by its own capability
  assign wake_mask = `CFL_WAKE_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < `CFL_NSRC; gi = gi + 1) begin : g_wake
      assign wake_hit[gi] = irq_pend[gi] & wake_mask[gi];
    end
  endgenerate

  assign wake_any = |wake_hit;

  always @* begin
    case (st_q)
      ST_RUN: begin
        if (ex_valid && ex_op == `CFL_OP_HALT) begin
          st_d = ST_HALT;
        end else begin
          st_d = ST_RUN;
        end
      end
      ST_HALT: begin
        // Wake also on entry, so a taken interrupt never leaves the core asleep
        if (wake_any || irq_enter) begin
          st_d = ST_RUN;
        end else begin
          st_d = ST_HALT;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      st_q <= ST_RUN;
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic and flag next value

  always @* begin
    cin  = (ex_op == `CFL_OP_ADC) ? cc_q[`CFL_BIT_C] : 1'b0;
    sum9 = {1'b0, ex_a} + {1'b0, ex_b} + {8'h00, cin};
    sum5 = {1'b0, ex_a[3:0]} + {1'b0, ex_b[3:0]} + {4'h0, cin};
    dif9 = {1'b0, ex_a} - {1'b0, ex_b};
    case (ex_op)
      `CFL_OP_ADD, `CFL_OP_ADC: res = sum9[7:0];
      `CFL_OP_SUB:              res = dif9[7:0];
      default:                  res = ex_a;
    endcase
  end

  always @* begin
    cc_d     = cc_q;
    carry_ev = 1'b0;
    // Register port write has the lowest weight
    if (reg_wr && reg_addr == `CFL_ADDR_CC) begin
      cc_d = reg_wdata | `CFL_CC_ONES;
    end
    if (ex_valid) begin
      case (ex_op)
        `CFL_OP_ADD, `CFL_OP_ADC: begin
          cc_d[`CFL_BIT_H] = sum5[`CFL_HC_BIT];
          cc_d[`CFL_BIT_N] = res[`CFL_ALU_MSB];
          cc_d[`CFL_BIT_Z] = (res == `CFL_ZERO8);
          cc_d[`CFL_BIT_C] = sum9[8];
          carry_ev         = sum9[8];
        end
        `CFL_OP_SUB: begin
          cc_d[`CFL_BIT_N] = res[`CFL_ALU_MSB];
          cc_d[`CFL_BIT_Z] = (res == `CFL_ZERO8);
          cc_d[`CFL_BIT_C] = dif9[8];
          carry_ev         = dif9[8];
        end
        `CFL_OP_LOGIC: begin
          cc_d[`CFL_BIT_N] = res[`CFL_ALU_MSB];
          cc_d[`CFL_BIT_Z] = (res == `CFL_ZERO8);
        end
        `CFL_OP_SHIFT: begin
          cc_d[`CFL_BIT_N] = res[`CFL_ALU_MSB];
          cc_d[`CFL_BIT_Z] = (res == `CFL_ZERO8);
          cc_d[`CFL_BIT_C] = ex_cbit;
        end
        `CFL_OP_BTJT: begin
          cc_d[`CFL_BIT_C] = ex_cbit;
        end
        `CFL_OP_SCF: begin
          cc_d[`CFL_BIT_C] = 1'b1;
        end
        `CFL_OP_RCF: begin
          cc_d[`CFL_BIT_C] = 1'b0;
        end
        `CFL_OP_RIM, `CFL_OP_HALT, `CFL_OP_WFI: begin
          // Enable, halt and wait instructions set level 0 (code 10) and so open interrupts
          {cc_d[`CFL_BIT_PHI], cc_d[`CFL_BIT_PLO]} = `CFL_LVL_MAIN;
        end
        `CFL_OP_SIM: begin
          {cc_d[`CFL_BIT_PHI], cc_d[`CFL_BIT_PLO]} = `CFL_LVL_OFF;
        end
        `CFL_OP_INTERRUPT_RETURN_INSTR, `CFL_OP_POP: begin
          cc_d = ex_a | `CFL_CC_ONES;
        end
        `CFL_OP_BITCTL: begin
          cc_d[ex_bit_sel] = ex_bit_val;
          cc_d             = cc_d | `CFL_CC_ONES;
        end
        default: begin
          cc_d = cc_d;
        end
      endcase
    end
    // Hardware entry wins over any software change of the level
    if (irq_enter) begin
      {cc_d[`CFL_BIT_PHI], cc_d[`CFL_BIT_PLO]} = irq_level;
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      cc_q       <= `CFL_CC_RESET;
      alu_result <= `CFL_ZERO8;
    end else begin
      cc_q <= cc_d;
      if (ex_valid) begin
        alu_result <= res;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Event status, mask and interrupt line

  assign ev[`CFL_EV_ENTRY] = irq_enter;
  assign ev[`CFL_EV_WAKE]  = halted & (wake_any | irq_enter);
  assign ev[`CFL_EV_CARRY] = ex_valid & carry_ev;

  generate
    for (gi = 0; gi < `CFL_NEV; gi = gi + 1) begin : g_stat
      always @(posedge clk) begin
        if (!rst_b) begin
          stat_q[gi] <= 1'b0;
        end else if (ev[gi]) begin
          // A new event beats a clear in the same cycle
          stat_q[gi] <= 1'b1;
        end else if (reg_wr && reg_addr == `CFL_ADDR_STAT && reg_wdata[gi]) begin
          stat_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_out = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Register port

  always @(posedge clk) begin
    if (!rst_b) begin
      flash_program_control_status_q <= `CFL_FLASH_PROGRAM_CONTROL_STATUS_RESET;
      mask_q <= {`CFL_NEV{1'b0}};
    end else if (reg_wr) begin
      if (reg_addr == `CFL_ADDR_FLASH_PROGRAM_CONTROL_STATUS) begin
        flash_program_control_status_q <= reg_wdata;
      end
      if (reg_addr == `CFL_ADDR_MASK) begin
        mask_q <= reg_wdata[`CFL_NEV-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      reg_rdata <= `CFL_ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        `CFL_ADDR_CC:   reg_rdata <= cc_q;
        `CFL_ADDR_FLASH_PROGRAM_CONTROL_STATUS: reg_rdata <= flash_program_control_status_q;
        `CFL_ADDR_STAT: reg_rdata <= {{(8-`CFL_NEV){1'b0}}, stat_q};
        `CFL_ADDR_MASK: reg_rdata <= {{(8-`CFL_NEV){1'b0}}, mask_q};
        default:        reg_rdata <= `CFL_ZERO8;
      endcase
    end else begin
      reg_rdata <= `CFL_ZERO8;
    end
  end

endmodule
`default_nettype wire

// file: common/cfl_defs.vh
// Constants of the CPU flag, priority and vector block
`ifndef CFL_DEFS_VH
`define CFL_DEFS_VH

// Flag and priority register layout
`define CFL_BIT_C        0
`define CFL_BIT_Z        1
`define CFL_BIT_N        2
`define CFL_BIT_PLO      3
`define CFL_BIT_H        4
`define CFL_BIT_PHI      5
`define CFL_CC_RESET     8'hE8
`define CFL_CC_ONES      8'hC0
`define CFL_ALU_MSB      7
`define CFL_HC_BIT       4

// Priority level codes as {high, low}
`define CFL_LVL_MAIN     2'h2
`define CFL_LVL_ONE      2'h1
`define CFL_LVL_TWO      2'h0
`define CFL_LVL_OFF      2'h3

// Execution operation codes
`define CFL_OP_NONE      4'h0
`define CFL_OP_ADD       4'h1
`define CFL_OP_ADC       4'h2
`define CFL_OP_SUB       4'h3
`define CFL_OP_LOGIC     4'h4
`define CFL_OP_SHIFT     4'h5
`define CFL_OP_BTJT      4'h6
`define CFL_OP_SCF       4'h7
`define CFL_OP_RCF       4'h8
`define CFL_OP_RIM       4'h9
`define CFL_OP_SIM       4'hA
`define CFL_OP_INTERRUPT_RETURN_INSTR      4'hB
`define CFL_OP_HALT      4'hC
`define CFL_OP_WFI       4'hD
`define CFL_OP_POP       4'hE
`define CFL_OP_BITCTL    4'hF

// Interrupt sources and vectors
`define CFL_NSRC         5
`define CFL_SRC_FLASH    3'h0
`define CFL_SRC_USB      3'h1
`define CFL_SRC_PA       3'h2
`define CFL_SRC_PB       3'h3
`define CFL_SRC_PC       3'h4
`define CFL_VEC_FLASH    16'hFFFA
`define CFL_VEC_USB      16'hFFF8
`define CFL_VEC_PA       16'hFFF6
`define CFL_VEC_PB       16'hFFF4
`define CFL_VEC_PC       16'hFFF2
`define CFL_VEC_NONE     16'h0000
`define CFL_WAKE_MASK    5'h1F

// Register port offsets
`define CFL_ADDR_CC      3'h0
`define CFL_ADDR_FLASH_PROGRAM_CONTROL_STATUS    3'h1
`define CFL_ADDR_STAT    3'h2
`define CFL_ADDR_MASK    3'h3
`define CFL_FLASH_PROGRAM_CONTROL_STATUS_RESET   8'h00
`define CFL_ZERO8        8'h00

// Status bits
`define CFL_EV_ENTRY     0
`define CFL_EV_WAKE      1
`define CFL_EV_CARRY     2
`define CFL_NEV          3

`endif

// file: src/cfl_vector_rom.v
// Fixed vector address and halt-wake lookup per interrupt source
`timescale 1ns/1ps
`default_nettype none
`include "cfl_defs.vh"

module cfl_vector_rom (
  input  wire [2:0]  src,
  output reg  [15:0] vec_addr,
  output reg         can_wake
);

  always @* begin
    case (src)
      `CFL_SRC_FLASH: begin
        vec_addr = `CFL_VEC_FLASH;
        can_wake = 1'b1;
      end
      `CFL_SRC_USB: begin
        vec_addr = `CFL_VEC_USB;
        can_wake = 1'b1;
      end
      `CFL_SRC_PA: begin
        vec_addr = `CFL_VEC_PA;
        can_wake = 1'b1;
      end
      `CFL_SRC_PB: begin
        vec_addr = `CFL_VEC_PB;
        can_wake = 1'b1;
      end
      `CFL_SRC_PC: begin
        vec_addr = `CFL_VEC_PC;
        can_wake = 1'b1;
      end
      default: begin
        // Higher sources are served elsewhere
        vec_addr = `CFL_VEC_NONE;
        can_wake = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// file: verification/cfl_prio_model.sv
// Interrupt controller model: per-source software priority lookup
`timescale 1ns/1ps
`default_nettype none
module cfl_prio_model #(
  parameter [9:0] PRIO = 10'h1B4
) (
  input  wire logic [2:0] src,
  output logic      [1:0] level
);
  // Sources beyond the mapped five get the disabled level
  assign level = (src < 3'h5) ? PRIO[src*2 +: 2] : 2'h3;
endmodule
`default_nettype wire

// file: verification/cfl_flags_assertions.sv
// Port-level checker for the flag, priority and vector block
`timescale 1ns/1ps
`default_nettype none
`include "cfl_defs.vh"
module cfl_flags_checker (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        ex_valid,
  input wire logic [3:0]  ex_op,
  input wire logic [7:0]  ex_a,
  input wire logic [7:0]  ex_b,
  input wire logic        irq_enter,
  input wire logic [2:0]  irq_src,
  input wire logic [1:0]  irq_level,
  input wire logic [4:0]  irq_pend,
  input wire logic [7:0]  state_out,
  input wire logic [1:0]  cur_level,
  input wire logic        irq_disabled,
  input wire logic [7:0]  alu_result,
  input wire logic [15:0] vec_addr,
  input wire logic        vec_wake,
  input wire logic        halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  property p_half;
    ex_valid && ex_op == `CFL_OP_ADD |=> state_out[4] == ({1'b0, $past(ex_a[3:0])} + $past(ex_b[3:0]) > 5'hF);
  endproperty
  a_half: assert property (p_half) else $error("half carry wrong");
  property p_neg;
    ex_valid && ex_op inside {[`CFL_OP_ADD:`CFL_OP_SHIFT]} |=> state_out[2] == alu_result[7];
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  property p_zero;
    ex_valid && ex_op inside {[`CFL_OP_ADD:`CFL_OP_SHIFT]} |=> state_out[1] == (alu_result == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_carry;
    ex_valid && ex_op == `CFL_OP_ADD |=> state_out[0] == ({1'b0, $past(ex_a)} + $past(ex_b) > 9'h0FF);
  endproperty
  a_carry: assert property (p_carry) else $error("add carry wrong");
  property p_setclr;
    ex_valid && (ex_op == `CFL_OP_SCF || ex_op == `CFL_OP_RCF) |=> state_out[0] == $past(ex_op == `CFL_OP_SCF);
  endproperty
  a_setclr: assert property (p_setclr) else $error("carry set or clear wrong");
  property p_level;
    cur_level == {state_out[5], state_out[3]} && irq_disabled == (cur_level == 2'h3);
  endproperty
  a_level: assert property (p_level) else $error("level code wrong");
  property p_entry;
    irq_enter |=> cur_level == $past(irq_level);
  endproperty
  a_entry: assert property (p_entry) else $error("entry level wrong");
  property p_disable;
    ex_valid && ex_op == `CFL_OP_SIM && !irq_enter |=> irq_disabled ##1 (irq_disabled || $past(ex_valid) || $past(irq_enter));
  endproperty
  a_disable: assert property (p_disable) else $error("disable not taken");
  property p_pop;
    ex_valid && ex_op == `CFL_OP_POP && !irq_enter |=> state_out == ($past(ex_a) | 8'hC0);
  endproperty
  a_pop: assert property (p_pop) else $error("pop image wrong");
  property p_vec;
    irq_enter |=> vec_wake == ($past(irq_src) < 3'h5)
      && vec_addr == (vec_wake ? 16'hFFFA - {$past(irq_src), 1'b0} : 16'h0000);
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_wake;
    halted && irq_pend != 5'h00 |=> !halted;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake from halt");
endmodule
bind cfl_flags cfl_flags_checker u_chk (.clk, .rst_b, .ex_valid, .ex_op, .ex_a, .ex_b, .irq_enter, .irq_src,
  .irq_level, .irq_pend, .state_out, .cur_level, .irq_disabled, .alu_result, .vec_addr, .vec_wake, .halted);
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench of the flag, priority and vector block
`timescale 1ns/1ps
`default_nettype none
`include "cfl_defs.vh"
module testbench;
  localparam [9:0] PRIO = 10'h1B4;
  logic clk = 0, rst_b = 0, ex_valid = 0, ex_cbit = 0, ex_bit_val = 0, irq_enter = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0]  ex_op = 0;
  logic [7:0]  ex_a = 0, ex_b = 0, reg_wdata = 0, cc = 8'hE8;
  logic [2:0]  ex_bit_sel = 0, irq_src = 0, reg_addr = 0;
  logic [4:0]  irq_pend = 0;
  logic [31:0] rnd = 32'hED4326AA;
  logic [15:0] nx;
  wire  [1:0]  irq_level, cur_level;
  wire  [7:0]  reg_rdata, state_out, alu_result;
  wire  [15:0] vec_addr;
  wire         irq_disabled, vec_wake, halted, irq_out;
  integer      failures = 0, samples_checked = 0, i;
  cfl_prio_model #(.PRIO(PRIO)) u_prio (.src(irq_src), .level(irq_level));
  cfl_flags u_dut (.clk, .rst_b, .ex_valid, .ex_op, .ex_a, .ex_b, .ex_cbit, .ex_bit_sel, .ex_bit_val, .irq_enter,
    .irq_src, .irq_level, .irq_pend, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .state_out, .cur_level,
    .irq_disabled, .alu_result, .vec_addr, .vec_wake, .halted, .irq_out);
  initial forever #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Reference flags: returns {result, next register image}
  function automatic [15:0] nxt(input [3:0] o, input [7:0] a, b, c, input ci);
    reg [8:0] s;
    reg [4:0] h;
    reg [7:0] n;
    begin
      n = c;
      s = {1'b0, a};
      h = a[3:0] + b[3:0] + ((o == `CFL_OP_ADC) ? c[0] : 1'b0);
      case (o)
        `CFL_OP_ADD, `CFL_OP_ADC: begin
          s = a + b + ((o == `CFL_OP_ADC) ? c[0] : 1'b0);
          n[4] = h[4];
          n[0] = s[8];
        end
        `CFL_OP_SUB: begin
          s = a - b;
          n[0] = a < b;
        end
        `CFL_OP_SHIFT, `CFL_OP_BTJT: n[0] = ci;
        `CFL_OP_SCF: n[0] = 1'b1;
        `CFL_OP_RCF: n[0] = 1'b0;
        `CFL_OP_RIM, `CFL_OP_HALT, `CFL_OP_WFI: {n[5], n[3]} = 2'h2;
        `CFL_OP_SIM: {n[5], n[3]} = 2'h3;
        `CFL_OP_INTERRUPT_RETURN_INSTR, `CFL_OP_POP: n = a | 8'hC0;
        `CFL_OP_BITCTL: if (a[2:0] < 3'h6) n[a[2:0]] = b[0];
        default: ;
      endcase
      if (o >= `CFL_OP_ADD && o <= `CFL_OP_SHIFT) begin
        n[2] = s[7];
        n[1] = (s[7:0] == 8'h00);
      end
      nxt = {s[7:0], n};
    end
  endfunction
  task chk(input [15:0] g, input [15:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task op(input [3:0] o, input [7:0] a, input [7:0] b, input ci);
    @(posedge clk);
    ex_valid <= 1; ex_op <= o; ex_a <= a; ex_b <= b; ex_cbit <= ci; ex_bit_sel <= a[2:0]; ex_bit_val <= b[0];
    nx = nxt(o, a, b, cc, ci);
    cc = nx[7:0];
    @(posedge clk);
    ex_valid <= 0;
    #1;
    chk(state_out, cc);
    chk(alu_result, nx[15:8]);
  endtask
  task wr(input [2:0] a, input [7:0] d);
    @(posedge clk);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 0;
    #1;
  endtask
  task rd(input [2:0] a, input [7:0] e);
    @(posedge clk);
    reg_rd <= 1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 0;
    #1 chk(reg_rdata, e);
  endtask
  task ent(input [2:0] s);
    @(posedge clk);
    irq_enter <= 1; irq_src <= s;
    @(posedge clk);
    irq_enter <= 0;
    #1;
    {cc[5], cc[3]} = (s < 3'h5) ? PRIO[s*2 +: 2] : 2'h3;
    chk(cur_level, {cc[5], cc[3]});
    chk(irq_disabled, {cc[5], cc[3]} == 2'h3);
    chk(vec_addr, (s < 3'h5) ? 16'hFFFA - 2 * s : 16'h0000);
    chk(vec_wake, s < 3'h5);
  endtask
  task tally_and_finish;
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("test watchdog expired");
    tally_and_finish;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1;
    rd(0, 8'hE8); rd(1, 8'h00); rd(3, 8'h00); wr(1, 8'hA5); rd(1, 8'hA5);
    wr(5, 8'hFF); rd(5, 8'h00);
    $display("test registers done");
    op(`CFL_OP_ADD, 8'h0F, 8'h01, 0); op(`CFL_OP_ADD, 8'hFF, 8'h01, 0); op(`CFL_OP_ADC, 8'h7F, 8'h00, 0);
    op(`CFL_OP_SUB, 8'h00, 8'h01, 0); op(`CFL_OP_SUB, 8'h44, 8'h44, 0);
    repeat (40) begin
      rnd = lfsr(rnd);
      op(4'h1 + rnd[2:0] % 5, rnd[15:8], rnd[23:16], rnd[24]);
    end
    $display("test arithmetic done");
    // Halt is left out here; it needs a wake event to continue
    for (i = 6; i < 16; i++) begin
      rnd = lfsr(rnd);
      if (i != 12) op(i[3:0], rnd[7:0], rnd[15:8], rnd[16]);
    end
    wr(0, 8'h15); cc = 8'hD5; rd(0, cc);
    $display("test instructions done");
    for (i = 0; i < 8; i++) ent(i[2:0]);
    $display("test vectors done");
    wr(2, 8'h07); wr(3, 8'h01); chk(irq_out, 0);
    ent(2); chk(irq_out, 1); rd(2, 8'h01);
    wr(3, 8'h00); chk(irq_out, 0); wr(3, 8'h01); chk(irq_out, 1);
    wr(2, 8'h01); chk(irq_out, 0); rd(3, 8'h01);
    $display("test interrupt done");
    for (i = 0; i < 5; i++) begin
      op(`CFL_OP_HALT, 8'h00, 8'h00, 0);
      chk(halted, 1);
      @(posedge clk) irq_pend <= 5'h01 << i;
      @(posedge clk) irq_pend <= 5'h00;
      #1 chk(halted, 0);
    end
    rd(2, 8'h02);
    op(`CFL_OP_HALT, 8'h00, 8'h00, 0); ent(0); chk(halted, 0);
    $display("test halt done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
